// file: hw/capture_defs.svh
// Offsets, field positions, reset values and counts of the two-channel capture unit.
// Assumes a word-addressed register index; the bus byte address is four times it.
`ifndef CAPTURE_DEFS_SVH
`define CAPTURE_DEFS_SVH

// Register indices (byte address = index * 4)
`define CAP1_FIFO_IDX   10'h140
`define CAP1_CTRL_IDX   10'h142
`define CAP2_FIFO_IDX   10'h144
`define CAP2_CTRL_IDX   10'h146
`define CAP_IRQ_IDX     10'h148

// Control register fields
`define CTL_MODE_LSB    0
`define CTL_BNE_BIT     3
`define CTL_OV_BIT      4
`define CTL_ICI_LSB     5
`define CTL_TMR_BIT     7
`define CTL_SIDL_BIT    13
`define CTL_RESET       16'h0000

// Interrupt register fields
`define IRQ_FLAG_LSB    0
`define IRQ_EN_LSB      8

// Capture geometry
`define CAP_WIDTH       16
`define CAP_DEPTH       4

// Prescaler terminal counts (every 4th and 16th rising edge)
`define PRESC4_LAST     4'h3
`define PRESC16_LAST    4'hf

// AXI responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// file: hw/capture_pkg.sv
// Types shared by the capture unit and its buffer.
// Assumes capture_defs.svh supplies the widths.
`include "capture_defs.svh"

package capture_pkg;

  // Capture trigger selection
  typedef enum logic [2:0] {
    MODE_OFF        = 3'h0,
    MODE_EVERY_EDGE = 3'h1,
    MODE_FALL       = 3'h2,
    MODE_RISE       = 3'h3,
    MODE_RISE4      = 3'h4,
    MODE_RISE16     = 3'h5,
    MODE_RSVD       = 3'h6,
    MODE_IRQ_ONLY   = 3'h7
  } mode_e;

  // Write channel phase, Gray along idle, part, response
  typedef enum logic [1:0] {
    WR_IDLE = 2'h0,
    WR_PART = 2'h1,
    WR_RESP = 2'h3
  } wr_state_e;

  // Read channel phase
  typedef enum logic {
    RD_IDLE = 1'b0,
    RD_RESP = 1'b1
  } rd_state_e;

  // Processor power state and timer run flags
  typedef struct packed {
    logic cpu_sleep;
    logic cpu_idle;
    logic timebase_a_on;
    logic timebase_b_on;
  } power_s;

  // Per-channel state
  typedef struct packed {
    mode_e       capture_mode_select;
    logic [1:0]  events_per_interrupt;
    logic        timebase_select;
    logic        stop_in_idle;
    logic        capture_overflow;
    logic        lock;
    logic        pin_q;
    logic [3:0]  presc;
    logic [1:0]  icnt;
    logic        capture_irq_flag;
    logic        capture_irq_enable;
  } chan_s;

  // Whole state of the top module
  typedef struct packed {
    wr_state_e   wr_st;
    logic        aw_got;
    logic        w_got;
    logic [9:0]  aw_idx;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    rd_state_e   rd_st;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    chan_s [1:0] ch;
    logic [1:0]  irq_req;
    logic        wake;
  } top_s;

endpackage : capture_pkg

// file: hw/capture_fifo.sv
// Shift-forward FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps

module capture_fifo
  import capture_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
)
(
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int CW = $clog2(DEPTH + 1);

  // Storage and fill level
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [CW-1:0]               count;
  } fifo_s;

  fifo_s st_reg;   // Registered state
  fifo_s st_next;  // Next state
  logic  push;     // Entry accepted
  logic  pop;      // Entry removed

  // Honest flags straight from the fill level
  assign in_ready  = (st_reg.count != CW'(DEPTH));
  assign out_valid = (st_reg.count != '0);
  assign out_data  = st_reg.mem[0];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  ////////////////////////////////////////////////////////////////////////////////
  // Next state: oldest entry always sits at index 0
  always_comb
  begin
    st_next = st_reg;
    // Pop advances every entry one place
    if (pop)
    begin
      for (int i = 0; i < DEPTH - 1; i++)
      begin
        st_next.mem[i] = st_reg.mem[i+1];
      end
    end
    // Push lands behind the last live entry
    if (push)
    begin
      st_next.mem[CW'(st_reg.count - CW'(pop))] = in_data;
    end
    st_next.count = CW'(st_reg.count + CW'(push) - CW'(pop));
  end

  // State register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

endmodule : capture_fifo

// file: hw/input_capture_two_channel.sv
// Two-channel input capture unit with an AXI4-Lite register slave.
// Assumes pins, time bases and power flags are synchronous to aclk.
`timescale 1ns/1ps
`include "capture_defs.svh"

// Contract
// - Mode field picks the capture trigger edge
// - Prescaler cleared when off or reset
// - Each channel buffers four 16-bit captures
// - Not-empty set until buffer fully read
// - Read gives oldest, shifts the rest
// - Capture into full buffer sets overflow
// - After overflow ignore events until emptied
// - Bit 7 selects time base, B default
// - Every-edge mode: flag each edge, no overflow
// - Mode 111 with enable wakes the device
// - Sleep: only mode 111 interrupt works
// - Idle capture needs timer on, stop-in-idle clear
// - Mode 111 in idle stores nothing
// - Bits 6:5 set events per interrupt
// - Per-channel flag, request only when enabled
// - Exactly two channels with own registers
module input_capture_two_channel
  import capture_pkg::*;
#(
  parameter int CAP_DEPTH = `CAP_DEPTH
)
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Capture pins and time bases
  input  wire logic [1:0]  capture_pin,
  input  wire logic [15:0] timebase_a,
  input  wire logic [15:0] timebase_b,
  input  wire power_s      power,
  // Interrupt and wake outputs
  output logic [1:0]       capture_irq_flag,
  output logic [1:0]       capture_irq,
  output logic             wake_req
);

  top_s s_reg;   // Registered state
  top_s s_next;  // Next state

  // Per-channel derived terms
  logic [1:0]       rise;          // Rising edge on the pin
  logic [1:0]       fall;          // Falling edge on the pin
  logic [1:0]       run_ok;        // Power state lets capture run
  logic [1:0]       edge_hit;      // Edge matches the mode
  logic [1:0]       presc_last;    // Prescaler at its terminal count
  logic [1:0]       cap_evt;       // Qualified capture event
  logic [1:0]       irq_only_evt;  // Interrupt-only event
  logic [1:0]       push;          // Offer to the buffer
  logic [1:0]       in_rdy;        // Buffer has room
  logic [1:0]       out_vld;       // Buffer holds data
  logic [1:0]       pop;           // Drain strobe from a read
  logic [1:0]       ovf;           // Event lost to a full buffer
  logic [1:0][15:0] stamp;         // Selected time base value
  logic [1:0][15:0] head;          // Oldest buffered value

  // Outputs straight from the state register
  assign s_axi_awready    = s_reg.awready;
  assign s_axi_wready     = s_reg.wready;
  assign s_axi_bvalid     = s_reg.bvalid;
  assign s_axi_bresp      = s_reg.bresp;
  assign s_axi_arready    = s_reg.arready;
  assign s_axi_rvalid     = s_reg.rvalid;
  assign s_axi_rdata      = s_reg.rdata;
  assign s_axi_rresp      = s_reg.rresp;
  assign capture_irq_flag = {s_reg.ch[1].capture_irq_flag, s_reg.ch[0].capture_irq_flag};
  assign capture_irq      = s_reg.irq_req;
  assign wake_req         = s_reg.wake;

  ////////////////////////////////////////////////////////////////////////////////
  // Per-channel event qualification and buffers
  for (genvar i = 0; i < 2; i++)
  begin : g_chan
    // Edge detect against last cycle's pin level
    assign rise[i] = capture_pin[i] & ~s_reg.ch[i].pin_q;
    assign fall[i] = ~capture_pin[i] & s_reg.ch[i].pin_q;

    // Sleep stops capture; idle needs the chosen timer and stop-in-idle low
    assign run_ok[i] = ~power.cpu_sleep &
                       ~(power.cpu_idle & (s_reg.ch[i].stop_in_idle |
                         ~(s_reg.ch[i].timebase_select ? power.timebase_a_on
                                                       : power.timebase_b_on)));

    // Trigger edge per mode
    always_comb
    begin
      edge_hit[i]   = 1'b0;
      presc_last[i] = 1'b1;
      case (s_reg.ch[i].capture_mode_select)
        MODE_EVERY_EDGE: edge_hit[i] = rise[i] | fall[i];
        MODE_FALL:       edge_hit[i] = fall[i];
        MODE_RISE:       edge_hit[i] = rise[i];
        MODE_RISE4:
        begin
          edge_hit[i]   = rise[i];
          presc_last[i] = (s_reg.ch[i].presc == `PRESC4_LAST);
        end
        MODE_RISE16:
        begin
          edge_hit[i]   = rise[i];
          presc_last[i] = (s_reg.ch[i].presc == `PRESC16_LAST);
        end
        default:         edge_hit[i] = 1'b0;  // Off, reserved, interrupt-only
      endcase
    end

    assign cap_evt[i]      = run_ok[i] & edge_hit[i] & presc_last[i];
    // Interrupt-only mode works in every power state, timer or not
    assign irq_only_evt[i] = (s_reg.ch[i].capture_mode_select == MODE_IRQ_ONLY) & rise[i];
    // Locked channel stays deaf until its buffer is empty
    assign push[i]         = cap_evt[i] & ~s_reg.ch[i].lock;
    assign ovf[i]          = push[i] & ~in_rdy[i] &
                             (s_reg.ch[i].capture_mode_select != MODE_EVERY_EDGE);
    // Timer B when the select bit is clear
    assign stamp[i]        = s_reg.ch[i].timebase_select ? timebase_a : timebase_b;

    // Four-deep buffer; a full buffer refuses and the event is dropped
    capture_fifo #(
      .WIDTH (`CAP_WIDTH),
      .DEPTH (CAP_DEPTH)
    ) u_fifo (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .in_valid  (push[i]),
      .in_ready  (in_rdy[i]),
      .in_data   (stamp[i]),
      .out_valid (out_vld[i]),
      .out_ready (pop[i]),
      .out_data  (head[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control word as software sees it
  function automatic logic [31:0] ctrl_word(input chan_s c, input logic bne);
    logic [31:0] w;
    w = '0;
    w[`CTL_MODE_LSB +: 3]   = c.capture_mode_select;
    w[`CTL_BNE_BIT]         = bne;
    w[`CTL_OV_BIT]          = c.capture_overflow;
    w[`CTL_ICI_LSB +: 2]    = c.events_per_interrupt;
    w[`CTL_TMR_BIT]         = c.timebase_select;
    w[`CTL_SIDL_BIT]        = c.stop_in_idle;
    return w;
  endfunction : ctrl_word

  // Control write with byte lanes; status bits are read-only
  function automatic chan_s ctrl_write(input chan_s c, input logic [31:0] d,
                                       input logic [3:0] be);
    chan_s r;
    r = c;
    if (be[0])
    begin
      r.capture_mode_select  = mode_e'(d[`CTL_MODE_LSB +: 3]);
      r.events_per_interrupt = d[`CTL_ICI_LSB +: 2];
      r.timebase_select      = d[`CTL_TMR_BIT];
    end
    if (be[1])
    begin
      r.stop_in_idle = d[`CTL_SIDL_BIT];
    end
    return r;
  endfunction : ctrl_write

  ////////////////////////////////////////////////////////////////////////////////
  // Next state: bus slave first, then hardware events so a set beats a clear
  always_comb
  begin
    logic        aw_hs;
    logic        w_hs;
    logic        have_aw;
    logic        have_w;
    logic [9:0]  widx;
    logic [31:0] wd;
    logic [3:0]  ws;
    logic [9:0]  ridx;
    logic        hit;
    aw_hs   = s_axi_awvalid & s_reg.awready;
    w_hs    = s_axi_wvalid & s_reg.wready;
    have_aw = s_reg.aw_got | aw_hs;
    have_w  = s_reg.w_got | w_hs;
    widx    = aw_hs ? s_axi_awaddr[11:2] : s_reg.aw_idx;
    wd      = w_hs ? s_axi_wdata : s_reg.wdata;
    ws      = w_hs ? s_axi_wstrb : s_reg.wstrb;
    ridx    = s_axi_araddr[11:2];
    hit     = 1'b0;
    s_next  = s_reg;
    pop     = 2'b00;

    // Write address and data taken in either order
    if (aw_hs)
    begin
      s_next.aw_got = 1'b1;
      s_next.aw_idx = s_axi_awaddr[11:2];
    end
    if (w_hs)
    begin
      s_next.w_got = 1'b1;
      s_next.wdata = s_axi_wdata;
      s_next.wstrb = s_axi_wstrb;
    end

    // Write phase machine
    case (s_reg.wr_st)
      WR_IDLE, WR_PART:
      begin
        if (have_aw && have_w)
        begin
          s_next.bvalid = 1'b1;
          s_next.bresp  = `RESP_OKAY;
          s_next.wr_st  = WR_RESP;
          case (widx)
            `CAP1_CTRL_IDX: s_next.ch[0] = ctrl_write(s_reg.ch[0], wd, ws);
            `CAP2_CTRL_IDX: s_next.ch[1] = ctrl_write(s_reg.ch[1], wd, ws);
            `CAP1_FIFO_IDX, `CAP2_FIFO_IDX: hit = 1'b1;  // Read-only, write dropped
            `CAP_IRQ_IDX:
            begin
              // Flags clear by writing one; enables are plain bits
              for (int i = 0; i < 2; i++)
              begin
                if (ws[0] && wd[`IRQ_FLAG_LSB + i])
                begin
                  s_next.ch[i].capture_irq_flag = 1'b0;
                end
                if (ws[1])
                begin
                  s_next.ch[i].capture_irq_enable = wd[`IRQ_EN_LSB + i];
                end
              end
            end
            default: s_next.bresp = `RESP_SLVERR;  // Unmapped address
          endcase
        end
        else if (have_aw || have_w)
        begin
          s_next.wr_st = WR_PART;
        end
      end
      WR_RESP:
      begin
        // Release both channels once the response is taken
        if (s_axi_bready)
        begin
          s_next.bvalid = 1'b0;
          s_next.aw_got = 1'b0;
          s_next.w_got  = 1'b0;
          s_next.wr_st  = WR_IDLE;
        end
      end
      default: s_next.wr_st = WR_IDLE;
    endcase
    s_next.awready = ~s_next.aw_got;
    s_next.wready  = ~s_next.w_got;

    // Read phase machine; a buffer read pops its oldest entry
    case (s_reg.rd_st)
      RD_IDLE:
      begin
        if (s_axi_arvalid && s_reg.arready)
        begin
          s_next.rvalid  = 1'b1;
          s_next.arready = 1'b0;
          s_next.rd_st   = RD_RESP;
          s_next.rresp   = `RESP_OKAY;
          s_next.rdata   = '0;
          case (ridx)
            `CAP1_FIFO_IDX:
            begin
              // Empty read returns zero and pops nothing
              s_next.rdata = {16'h0000, out_vld[0] ? head[0] : 16'h0000};
              pop[0]       = out_vld[0];
            end
            `CAP2_FIFO_IDX:
            begin
              s_next.rdata = {16'h0000, out_vld[1] ? head[1] : 16'h0000};
              pop[1]       = out_vld[1];
            end
            `CAP1_CTRL_IDX: s_next.rdata = ctrl_word(s_reg.ch[0], out_vld[0]);
            `CAP2_CTRL_IDX: s_next.rdata = ctrl_word(s_reg.ch[1], out_vld[1]);
            `CAP_IRQ_IDX:
            begin
              for (int i = 0; i < 2; i++)
              begin
                s_next.rdata[`IRQ_FLAG_LSB + i] = s_reg.ch[i].capture_irq_flag;
                s_next.rdata[`IRQ_EN_LSB + i]   = s_reg.ch[i].capture_irq_enable;
              end
            end
            default: s_next.rresp = `RESP_SLVERR;  // Unmapped address
          endcase
        end
        else
        begin
          s_next.arready = 1'b1;
        end
      end
      RD_RESP:
      begin
        if (s_axi_rready)
        begin
          s_next.rvalid  = 1'b0;
          s_next.arready = 1'b1;
          s_next.rd_st   = RD_IDLE;
        end
      end
      default: s_next.rd_st = RD_IDLE;
    endcase

    // Channel events after software writes, so hardware sets win
    s_next.wake = 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      s_next.ch[i].pin_q = capture_pin[i];
      // Prescaler: cleared while off, counts qualifying rising edges
      if (s_next.ch[i].capture_mode_select == MODE_OFF)
      begin
        s_next.ch[i].presc = 4'h0;
        s_next.ch[i].icnt  = 2'h0;
      end
      else if (run_ok[i] && rise[i] &&
               (s_reg.ch[i].capture_mode_select == MODE_RISE4 ||
                s_reg.ch[i].capture_mode_select == MODE_RISE16))
      begin
        s_next.ch[i].presc = presc_last[i] ? 4'h0 : 4'(s_reg.ch[i].presc + 4'h1);
      end
      // Overflow locks the channel; an emptied buffer releases it
      if (ovf[i])
      begin
        s_next.ch[i].capture_overflow = 1'b1;
        s_next.ch[i].lock             = 1'b1;
      end
      else if (s_reg.ch[i].lock && !out_vld[i])
      begin
        s_next.ch[i].capture_overflow = 1'b0;
        s_next.ch[i].lock             = 1'b0;
      end
      // Interrupt flag: every event in every-edge and interrupt-only modes
      if ((cap_evt[i] && s_reg.ch[i].capture_mode_select == MODE_EVERY_EDGE) ||
          irq_only_evt[i])
      begin
        s_next.ch[i].capture_irq_flag = 1'b1;
      end
      else if (push[i] && in_rdy[i])
      begin
        // Count stored captures against the events-per-interrupt code
        if (s_reg.ch[i].icnt == s_reg.ch[i].events_per_interrupt)
        begin
          s_next.ch[i].capture_irq_flag = 1'b1;
          s_next.ch[i].icnt             = 2'h0;
        end
        else
        begin
          s_next.ch[i].icnt = 2'(s_reg.ch[i].icnt + 2'h1);
        end
      end
      // Wake from sleep or idle on an enabled interrupt-only event
      if (irq_only_evt[i] && s_reg.ch[i].capture_irq_enable &&
          (power.cpu_sleep || power.cpu_idle))
      begin
        s_next.wake = 1'b1;
      end
      // Request only while the channel's enable is set
      s_next.irq_req[i] = s_next.ch[i].capture_irq_flag &
                          s_next.ch[i].capture_irq_enable;
    end
  end

  // State register; synchronous reset clears prescalers and selects timer B
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

endmodule : input_capture_two_channel

// file: test/pin_source.sv
// Far side: a digital level on each capture pin.
// Assumes the bench asks for a toggle with a one-cycle flip bit.
`timescale 1ns/1ps
module pin_source
(
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Toggle request, pins
  input  wire logic [1:0] flip,
  output logic      [1:0] pin
);
  // Driven level, changed just after an edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pin <= 2'h0;
    else
      pin <= pin ^ flip;
  end
endmodule : pin_source

// file: test/icap_chk.sv
// Checker: bus answers, flag and wake timing at the top ports.
// Assumes one clock domain, reset active low.
`timescale 1ns/1ps
module icap_chk
  import capture_pkg::*;
#(
  parameter int CAP_DEPTH = 4
)
(
  // Clock, reset, bus
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Pins, flags, wake
  input wire logic [1:0]  capture_pin,
  input wire logic [1:0]  capture_irq_flag,
  input wire logic [1:0]  capture_irq,
  input wire logic        wake_req
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_b_ans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid;
  endproperty
  a_b_ans: assert property (p_b_ans) else $error("no write answer");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("second read taken");
  property p_irq_gate;
    (capture_irq & ~capture_irq_flag) == 2'h0;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("request without flag");
  property p_flag_clr;
    $fell(capture_irq_flag[0]) |-> $past(s_axi_wvalid);
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag fell alone");
  property p_flag_pin;
    $rose(capture_irq_flag[1]) |-> $past(capture_pin[1]) != $past(capture_pin[1], 2);
  endproperty
  a_flag_pin: assert property (p_flag_pin) else $error("flag without edge");
  property p_wake_pin;
    wake_req |-> $past(capture_pin[0]) != $past(capture_pin[0], 2) ##1 !wake_req;
  endproperty
  a_wake_pin: assert property (p_wake_pin) else $error("bad wake pulse");
  c_b_wait: cover property (s_axi_bvalid && !s_axi_bready);
  c_wake: cover property (wake_req);
  c_irq1: cover property (capture_irq[1]);
endmodule : icap_chk
bind input_capture_two_channel icap_chk #(.CAP_DEPTH(CAP_DEPTH)) u_chk (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .capture_pin(capture_pin), .capture_irq_flag(capture_irq_flag),
  .capture_irq(capture_irq), .wake_req(wake_req));

// file: test/input_capture_two_channel_test.sv
// Bench: registers, capture modes, overflow, power states.
// Assumes pin_source and the checker are compiled first.
`timescale 1ns/1ps
`include "capture_defs.svh"
module input_capture_two_channel_test
  import capture_pkg::*;
;
  localparam logic [11:0] B1 = {`CAP1_FIFO_IDX, 2'h0};
  localparam logic [11:0] C1 = {`CAP1_CTRL_IDX, 2'h0};
  localparam logic [11:0] B2 = {`CAP2_FIFO_IDX, 2'h0};
  localparam logic [11:0] C2 = {`CAP2_CTRL_IDX, 2'h0};
  localparam logic [11:0] IQ = {`CAP_IRQ_IDX, 2'h0};
  logic aclk = 1'b0;
  logic aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, wake;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [31:0] seed = 32'hac45;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, flip, pin, flag, irq;
  logic [15:0] ta, tb;
  logic [15:0] v[4];
  logic [33:0] expq[$];
  power_s power;
  int n_mismatch = 0;
  int check_count = 0;
  int n_wake = 0;
  int cyc = 0;
  always #2.5 aclk = ~aclk;
  input_capture_two_channel u_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .capture_pin(pin), .timebase_a(ta), .timebase_b(tb), .power(power),
    .capture_irq_flag(flag), .capture_irq(irq), .wake_req(wake));
  pin_source u_pin (.aclk(aclk), .aresetn(aresetn), .flip(flip), .pin(pin));
  task automatic final_report();
    if (n_mismatch == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    check_count++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
      n_mismatch++;
    end
  endtask : chk
  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] r = 2'h0);
    expq.push_back({r, 32'h0});
    @(posedge aclk);
    awaddr <= a;
    wdata <= {16'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end while (awvalid || wvalid);
    bready <= 1'b1;
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
  endtask : wr
  // Read: rready comes a cycle late so the slave must hold its answer
  task automatic rd(input logic [11:0] a, input logic [15:0] d, input logic [1:0] r = 2'h0);
    expq.push_back({r, 16'h0, d});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
    end while (arvalid);
    rready <= 1'b1;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
  endtask : rd
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // New random timer values
  task automatic nt();
    seed = lfsr(seed);
    ta <= seed[15:0];
    tb <= seed[31:16];
  endtask : nt
  // n pin toggles, each given time to be seen
  task automatic tog(input int ch, input int n);
    repeat (n)
    begin
      @(posedge aclk);
      flip[ch] <= 1'b1;
      @(posedge aclk);
      flip[ch] <= 1'b0;
      repeat (3) @(posedge aclk);
    end
  endtask : tog
  // Answers checked in request order; hang guard
  always @(posedge aclk)
  begin
    if (bvalid && bready)
      chk({bresp, 32'h0}, expq.pop_front());
    if (rvalid && rready)
      chk({rresp, rdata}, expq.pop_front());
    if (wake)
      n_wake++;
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      final_report();
    end
  end
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, flip, ta, tb} = '0;
    wstrb = 4'hf;
    power = '{1'b0, 1'b0, 1'b1, 1'b1};
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(C1, 16'h0);
    rd(C2, 16'h0);
    rd(12'h524, 16'h0, 2'h2);
    wr(12'h524, 16'h1, 2'h2);
    wr(IQ, 16'h0300);
    wr(C1, 16'h0083);
    for (int i = 0; i < 5; i++)
    begin
      nt();
      v[i % 4] = (i < 4) ? seed[15:0] : v[i % 4];
      tog(0, 2);
    end
    rd(C1, 16'h009b);
    for (int i = 0; i < 3; i++)
      rd(B1, v[i]);
    tog(0, 2);
    rd(B1, v[3]);
    rd(C1, 16'h0083);
    rd(IQ, 16'h0301);
    wr(IQ, 16'h0301);
    wr(C2, 16'h0022);
    tog(1, 2);
    rd(IQ, 16'h0300);
    tog(1, 2);
    rd(IQ, 16'h0302);
    chk(34'({flag, irq}), 34'ha);
    wr(IQ, 16'h0100);
    chk(34'({flag, irq}), 34'h8);
    rd(B2, seed[31:16]);
    rd(B2, seed[31:16]);
    wr(IQ, 16'h0302);
    wr(C1, 16'h0061);
    tog(0, 1);
    rd(IQ, 16'h0301);
    tog(0, 5);
    rd(C1, 16'h0069);
    repeat (4) rd(B1, seed[31:16]);
    wr(C1, 16'h0084);
    tog(0, 6);
    wr(C1, 16'h0080);
    wr(C1, 16'h0084);
    tog(0, 6);
    rd(C1, 16'h0084);
    tog(0, 2);
    rd(C1, 16'h008c);
    rd(B1, seed[15:0]);
    wr(C1, 16'h0);
    wr(C1, 16'h0085);
    tog(0, 30);
    rd(C1, 16'h0085);
    tog(0, 2);
    rd(C1, 16'h008d);
    rd(B1, seed[15:0]);
    power <= '{1'b1, 1'b0, 1'b0, 1'b0};
    wr(C1, 16'h0003);
    tog(0, 2);
    rd(C1, 16'h0003);
    wr(C1, 16'h0007);
    tog(0, 2);
    chk(34'(n_wake), 34'h1);
    power <= '{1'b0, 1'b1, 1'b1, 1'b1};
    tog(0, 2);
    chk(34'(n_wake), 34'h2);
    rd(C1, 16'h0007);
    wr(C1, 16'h2003);
    tog(0, 2);
    rd(C1, 16'h2003);
    wr(C1, 16'h0003);
    tog(0, 2);
    rd(C1, 16'h000b);
    rd(B1, seed[31:16]);
    final_report();
  end
endmodule : input_capture_two_channel_test
